// ===== verilog/swpm_stop_wake.sv
// stop/wake power monitor: stop mode, ring wake, reset sequencing, pfi
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "swpm_params.svh"

// Function
// - stop bit write gates all clocks
// - only external interrupt, reset or kept-reference pfi ends stop
// - keep-alive bit keeps reference on in stop
// - kept reference lets pfi and reset wake
// - reference always on outside stop
// - ring select gives ring clock on wake
// - ring runs 65536 clocks then crystal
// - ring status bit shows ring is active
// - reset default wakes on crystal
// - suppress keeps strobe static except off-chip
// - strobe toggles at clock over four
// - timer rate bit picks 12 or 4
// - three timer rate bits act independently
// - power-up waits, counts 65536, releases reset
// - low supply holds reset without software
// - pfi vectors to 0033h top priority
// - control bit 5 enables pfi
// - warning sets sticky flag until cleared
// - guard AAh 55h opens three-cycle window
module swpm_stop_wake
  import swpm_pkg::*;
#(
  parameter int POR_CYCLES = `SWPM_POR_CLOCKS
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SWPM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire swpm_mon_s mon,
  input wire logic ext_wake,
  input wire logic offchip_move,
  output swpm_pwr_s pwr,
  output logic core_reset,
  output logic ring_active_status,
  output logic addr_strobe,
  output logic [2:0] timer_tick,
  output logic pfi_req,
  output logic [15:0] pfi_vector
);

  localparam logic [`SWPM_CNT_W-1:0] CNT_LAST =
    `SWPM_CNT_W'(POR_CYCLES - 1);

  // synchronisers for the comparator outputs
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic warn_meta_ff;
  logic warn_sync_ff;

  // sequencer and register state
  swpm_state_e state_ff;
  swpm_state_e nxt_state;
  logic [`SWPM_CNT_W-1:0] cnt_ff;
  logic [`SWPM_CNT_W-1:0] nxt_cnt;
  logic idle_ff;
  logic nxt_idle;
  logic [2:0] rate_ff;
  logic [2:0] nxt_rate;
  logic bgs_ff;
  logic nxt_bgs;
  logic ring_wake_select_ff;
  logic nxt_ring_wake_select;
  logic suppress_ff;
  logic nxt_suppress;
  logic pfie_ff;
  logic nxt_pfie;
  logic pfif_ff;
  logic nxt_pfif;
  logic armed_ff;
  logic nxt_armed;
  logic [1:0] win_ff;
  logic [1:0] nxt_win;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic slverr_ff;
  logic nxt_slverr;
  logic pfi_req_ff;
  logic nxt_pfi_req;
  logic [15:0] vector_ff;
  logic [15:0] nxt_vector;
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic strobe_ff;
  logic nxt_strobe;

  // decode helpers
  logic [9:0] idx;
  logic hit;
  logic wr_en;
  logic rd_setup;
  logic mon_valid;
  logic in_stop;
  logic [7:0] wbyte;

  assign idx = paddr[`SWPM_ADDR_W-1:2];
  assign wbyte = pwdata[7:0];
  assign hit = (paddr[1:0] == 2'h0) &&
               (idx == `SWPM_IDX_POWER_CONTROL ||
                idx == `SWPM_IDX_CLOCK_CONTROL ||
                idx == `SWPM_IDX_EXT_FLAGS ||
                idx == `SWPM_IDX_ACCESS_GUARD ||
                idx == `SWPM_IDX_WATCHDOG_AND_POWER_FAIL_CONTROL ||
                idx == `SWPM_IDX_PMR);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable;
  assign in_stop = (state_ff == ST_STOP);
  // monitor only trusted in stop when reference kept alive
  assign mon_valid = !in_stop || bgs_ff;

  // two-flop synchronisers; first stage read only by second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= 1'h1;
      warn_meta_ff <= 1'h0;
      warn_sync_ff <= 1'h0;
    end
    else
    begin
      rst_meta_ff <= mon.below_reset;
      rst_sync_ff <= rst_meta_ff;
      warn_meta_ff <= mon.below_warn;
      warn_sync_ff <= warn_meta_ff;
    end
  end

  // next values of sequencer, registers and bus answer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_idle = idle_ff;
    nxt_rate = rate_ff;
    nxt_bgs = bgs_ff;
    nxt_ring_wake_select = ring_wake_select_ff;
    nxt_suppress = suppress_ff;
    nxt_pfie = pfie_ff;
    nxt_pfif = pfif_ff;
    nxt_armed = armed_ff;
    nxt_win = (win_ff != 2'h0) ? win_ff - 2'h1 : 2'h0;
    nxt_rdata = rdata_ff;
    nxt_slverr = slverr_ff;

    // read data and error prepared in the setup cycle
    if (rd_setup)
    begin
      nxt_rdata = 32'h0;
      nxt_slverr = !hit;
      case (hit ? idx : 10'h000)
        `SWPM_IDX_POWER_CONTROL:
        begin
          nxt_rdata[`SWPM_POWER_CONTROL_IDLE] = idle_ff;
          nxt_rdata[`SWPM_POWER_CONTROL_STOP] = in_stop;
        end
        `SWPM_IDX_CLOCK_CONTROL:
          nxt_rdata[`SWPM_CLOCK_CONTROL_T0 +: 3] = rate_ff;
        `SWPM_IDX_EXT_FLAGS:
        begin
          nxt_rdata[`SWPM_EXTENDED_INTERRUPT_FLAGS_BGS] = bgs_ff;
          nxt_rdata[`SWPM_EXTENDED_INTERRUPT_FLAGS_RING_WAKE_SELECT] = ring_wake_select_ff;
          nxt_rdata[`SWPM_EXTENDED_INTERRUPT_FLAGS_RING_ACTIVE_STATUS] = (state_ff == ST_RING);
        end
        `SWPM_IDX_PMR:
          nxt_rdata[`SWPM_PMR_SUPPRESS] = suppress_ff;
        `SWPM_IDX_WATCHDOG_AND_POWER_FAIL_CONTROL:
        begin
          nxt_rdata[`SWPM_WATCHDOG_AND_POWER_FAIL_CONTROL_PFIE] = pfie_ff;
          nxt_rdata[`SWPM_WATCHDOG_AND_POWER_FAIL_CONTROL_PFIF] = pfif_ff;
        end
        default:
          nxt_rdata = 32'h0;
      endcase
    end

    // guard sequence tracking; any other write to a mapped register disarms
    if (wr_en)
    begin
      nxt_armed = 1'h0;
      if (idx == `SWPM_IDX_ACCESS_GUARD)
      begin
        if (wbyte == `SWPM_GUARD_KEY1)
          nxt_armed = 1'h1;
        else if (wbyte == `SWPM_GUARD_KEY2 && armed_ff)
          nxt_win = `SWPM_GUARD_WIN;
      end
    end

    // register writes, taken in the access cycle
    if (wr_en)
    begin
      case (idx)
        `SWPM_IDX_POWER_CONTROL:
        begin
          nxt_idle = wbyte[`SWPM_POWER_CONTROL_IDLE];
          if (wbyte[`SWPM_POWER_CONTROL_STOP] &&
              (state_ff == ST_CRYSTAL_CLOCK || state_ff == ST_RING))
            nxt_state = ST_STOP;
        end
        `SWPM_IDX_CLOCK_CONTROL:
          nxt_rate = wbyte[`SWPM_CLOCK_CONTROL_T0 +: 3];
        `SWPM_IDX_EXT_FLAGS:
        begin
          nxt_ring_wake_select = wbyte[`SWPM_EXTENDED_INTERRUPT_FLAGS_RING_WAKE_SELECT];
          if (win_ff != 2'h0)
            nxt_bgs = wbyte[`SWPM_EXTENDED_INTERRUPT_FLAGS_BGS];
        end
        `SWPM_IDX_PMR:
          nxt_suppress = wbyte[`SWPM_PMR_SUPPRESS];
        `SWPM_IDX_WATCHDOG_AND_POWER_FAIL_CONTROL:
        begin
          nxt_pfie = wbyte[`SWPM_WATCHDOG_AND_POWER_FAIL_CONTROL_PFIE];
          nxt_pfif = wbyte[`SWPM_WATCHDOG_AND_POWER_FAIL_CONTROL_PFIF];
        end
        default:
          nxt_idle = idle_ff;
      endcase
    end

    // warning sets the sticky flag; set beats a clearing write
    if (warn_sync_ff && mon_valid)
      nxt_pfif = 1'h1;

    // sequencer
    case (state_ff)
      ST_POR:
      begin
        if (!rst_sync_ff)
        begin
          nxt_cnt = cnt_ff + `SWPM_CNT_W'(1);
          if (cnt_ff == CNT_LAST)
          begin
            nxt_state = ST_CRYSTAL_CLOCK;
            nxt_cnt = '0;
          end
        end
      end
      ST_STOP:
      begin
        // only external or kept-alive supply events wake
        if (ext_wake || (bgs_ff && warn_sync_ff && pfie_ff))
        begin
          nxt_state = ring_wake_select_ff ? ST_RING : ST_CRYSTAL_CLOCK;
          nxt_cnt = '0;
        end
      end
      ST_RING:
      begin
        if (nxt_state == ST_RING)
        begin
          nxt_cnt = cnt_ff + `SWPM_CNT_W'(1);
          if (cnt_ff == CNT_LAST)
          begin
            nxt_state = ST_CRYSTAL_CLOCK;
            nxt_cnt = '0;
          end
        end
      end
      ST_CRYSTAL_CLOCK:
        nxt_cnt = '0;
      default:
      begin
        nxt_state = ST_POR;
        nxt_cnt = '0;
      end
    endcase

    // low supply forces and holds reset, stop included if monitored
    if (rst_sync_ff && mon_valid)
    begin
      nxt_state = ST_POR;
      nxt_cnt = '0;
    end
  end

  // register the sequencer and software state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_POR;
      cnt_ff <= '0;
      idle_ff <= `SWPM_RST_BIT;
      rate_ff <= `SWPM_RST_CLOCK_CONTROL;
      bgs_ff <= `SWPM_RST_BIT;
      ring_wake_select_ff <= `SWPM_RST_BIT;
      suppress_ff <= `SWPM_RST_BIT;
      pfie_ff <= `SWPM_RST_BIT;
      pfif_ff <= `SWPM_RST_BIT;
      armed_ff <= 1'h0;
      win_ff <= 2'h0;
      rdata_ff <= 32'h0;
      slverr_ff <= 1'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idle_ff <= nxt_idle;
      rate_ff <= nxt_rate;
      bgs_ff <= nxt_bgs;
      ring_wake_select_ff <= nxt_ring_wake_select;
      suppress_ff <= nxt_suppress;
      pfie_ff <= nxt_pfie;
      pfif_ff <= nxt_pfif;
      armed_ff <= nxt_armed;
      win_ff <= nxt_win;
      rdata_ff <= nxt_rdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // next values of strobe divider and interrupt request
  always_comb
  begin
    nxt_div = in_stop ? div_ff : div_ff + 2'h1;
    if (suppress_ff && !offchip_move)
      nxt_strobe = 1'h0;
    else
      nxt_strobe = div_ff[1] && !in_stop;
    nxt_pfi_req = pfie_ff && pfif_ff && (state_ff != ST_POR);
    nxt_vector = nxt_pfi_req ? `SWPM_VECTOR_PFI : 16'h0;
  end

  // register strobe and interrupt request
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_ff <= 2'h0;
      strobe_ff <= 1'h0;
      pfi_req_ff <= 1'h0;
      vector_ff <= 16'h0;
    end
    else
    begin
      div_ff <= nxt_div;
      strobe_ff <= nxt_strobe;
      pfi_req_ff <= nxt_pfi_req;
      vector_ff <= nxt_vector;
    end
  end

  // per-timer prescaler, 12 or 4 clocks per tick
  genvar t;
  generate
    for (t = 0; t < 3; t++)
    begin : g_timer
      logic [3:0] pre_ff;
      logic [3:0] nxt_pre;
      logic tick_ff;
      logic nxt_tick;
      logic [3:0] div;

      always_comb
      begin
        div = rate_ff[t] ? `SWPM_DIV_FAST : `SWPM_DIV_SLOW;
        nxt_pre = pre_ff;
        nxt_tick = 1'h0;
        if (!in_stop && state_ff != ST_POR)
        begin
          if (pre_ff >= div - 4'h1)
          begin
            nxt_pre = 4'h0;
            nxt_tick = 1'h1;
          end
          else
            nxt_pre = pre_ff + 4'h1;
        end
      end

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pre_ff <= 4'h0;
          tick_ff <= 1'h0;
        end
        else
        begin
          pre_ff <= nxt_pre;
          tick_ff <= nxt_tick;
        end
      end

      assign timer_tick[t] = tick_ff;
    end
  endgenerate

  // outputs
  assign prdata = rdata_ff;
  assign pready = psel && penable;
  assign pslverr = psel && penable && slverr_ff;
  assign pwr = '{clocks_off: in_stop,
    crystal_on: !in_stop && !(state_ff == ST_POR && rst_sync_ff),
    ring_on: (state_ff == ST_RING),
    bandgap_on: !in_stop || bgs_ff};
  assign core_reset = (state_ff == ST_POR);
  assign ring_active_status = (state_ff == ST_RING);
  assign addr_strobe = strobe_ff;
  assign pfi_req = pfi_req_ff;
  assign pfi_vector = vector_ff;

endmodule : swpm_stop_wake

// ===== verilog/swpm_params.svh
// offsets, field positions, reset values and counts of the stop/wake block
`ifndef SWPM_PARAMS_SVH
`define SWPM_PARAMS_SVH

// register indices; byte address is four times the index
`define SWPM_IDX_POWER_CONTROL 10'h087
`define SWPM_IDX_CLOCK_CONTROL 10'h08E
`define SWPM_IDX_EXT_FLAGS 10'h091
`define SWPM_IDX_ACCESS_GUARD 10'h0C7
`define SWPM_IDX_WATCHDOG_AND_POWER_FAIL_CONTROL 10'h0D8
`define SWPM_IDX_PMR 10'h0F0
`define SWPM_ADDR_W 12

// field positions
`define SWPM_POWER_CONTROL_IDLE 0
`define SWPM_POWER_CONTROL_STOP 1
`define SWPM_EXTENDED_INTERRUPT_FLAGS_BGS 0
`define SWPM_EXTENDED_INTERRUPT_FLAGS_RING_WAKE_SELECT 1
`define SWPM_EXTENDED_INTERRUPT_FLAGS_RING_ACTIVE_STATUS 2
`define SWPM_PMR_SUPPRESS 2
`define SWPM_CLOCK_CONTROL_T0 3
`define SWPM_WATCHDOG_AND_POWER_FAIL_CONTROL_PFIF 4
`define SWPM_WATCHDOG_AND_POWER_FAIL_CONTROL_PFIE 5

// guard unlock sequence and window length in clocks
`define SWPM_GUARD_KEY1 8'hAA
`define SWPM_GUARD_KEY2 8'h55
`define SWPM_GUARD_WIN 2'h3

// reset values
`define SWPM_RST_CLOCK_CONTROL 3'h0
`define SWPM_RST_BIT 1'h0

// timer prescale divisors, power-fail vector, power-up count and its width
`define SWPM_DIV_SLOW 4'hC
`define SWPM_DIV_FAST 4'h4
`define SWPM_VECTOR_PFI 16'h0033
`define SWPM_POR_CLOCKS 65536
`define SWPM_CNT_W 17

`endif

// ===== verilog/swpm_pkg.sv
// types shared by the stop/wake power monitor
package swpm_pkg;

  // operating state of the power sequencer
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_CRYSTAL_CLOCK = 2'b01,
    ST_STOP = 2'b10,
    ST_RING = 2'b11
  } swpm_state_e;

  // raw comparator outputs of the analogue supply monitor
  typedef struct packed {
    logic below_reset;
    logic below_warn;
  } swpm_mon_s;

  // controls toward oscillators and reference
  typedef struct packed {
    logic clocks_off;
    logic crystal_on;
    logic ring_on;
    logic bandgap_on;
  } swpm_pwr_s;

endpackage : swpm_pkg

// ===== verif/swpm_supply_model.sv
// supply monitor comparators driven from a commanded supply level
`timescale 1ns/10ps
module swpm_supply_model import swpm_pkg::*;
(
  input wire logic [1:0] level,
  output swpm_mon_s mon
);
  // level 0 healthy, 1 below warning, 2 below reset and warning
  assign mon = '{below_reset: (level == 2'h2),
    below_warn: (level != 2'h0)};
endmodule : swpm_supply_model

// ===== verif/swpm_stop_wake_properties.sv
// port checker of the stop/wake power monitor
`timescale 1ns/10ps
module swpm_stop_wake_chk import swpm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire swpm_mon_s mon,
  input wire swpm_pwr_s pwr,
  input wire logic core_reset,
  input wire logic ring_active_status,
  input wire logic [2:0] timer_tick,
  input wire logic pfi_req,
  input wire logic [15:0] pfi_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // bus answer and error qualification
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  // timer 0 tick never closer than four clocks
  property p_tick; timer_tick[0] |=> !timer_tick[0] [*3]; endproperty
  a_tick: assert property (p_tick) else $error("tick too early");
  // warning vector shown only with request
  property p_vec; pfi_req |-> pfi_vector == 16'h0033; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_vec0; !pfi_req |-> pfi_vector == 16'h0000; endproperty
  a_vec0: assert property (p_vec0) else $error("stray vector");
  // status follows the active clock
  property p_ring; ring_active_status == pwr.ring_on; endproperty
  a_ring: assert property (p_ring) else $error("ring status off");
  // ring clock is only entered on leaving stop
  property p_wake;
    $rose(ring_active_status) |-> $past(pwr.clocks_off);
  endproperty
  a_wake: assert property (p_wake) else $error("ring without stop");
  // stop gates the crystal, reference on outside stop
  property p_stop; pwr.clocks_off |-> !pwr.crystal_on; endproperty
  a_stop: assert property (p_stop) else $error("crystal in stop");
  property p_bg; !pwr.clocks_off |-> pwr.bandgap_on; endproperty
  a_bg: assert property (p_bg) else $error("reference off");
  // low supply forces reset after synchronising
  property p_rst;
    (mon.below_reset && !pwr.clocks_off) [*3] |=> core_reset;
  endproperty
  a_rst: assert property (p_rst) else $error("no reset");
  cover property (pfi_req);
  cover property (pwr.ring_on);
  cover property (pwr.clocks_off);
endmodule : swpm_stop_wake_chk

bind swpm_stop_wake swpm_stop_wake_chk u_chk (.clk, .nrst, .psel,
  .penable, .pready, .pslverr, .mon, .pwr, .core_reset,
  .ring_active_status, .timer_tick, .pfi_req, .pfi_vector);

// ===== verif/swpm_stop_wake_test.sv
// self-checking bench of the stop/wake power monitor
`timescale 1ns/10ps
module swpm_stop_wake_test import swpm_pkg::*;
;
  typedef struct packed
  {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
  } swpm_row_s;
  // register index, written value, expected read back
  localparam swpm_row_s ROWS [5] = '{{10'h08E, 8'h38, 8'h38},
    {10'h0F0, 8'h04, 8'h04}, {10'h0D8, 8'h20, 8'h20},
    {10'h091, 8'h03, 8'h02}, {10'h087, 8'h01, 8'h01}};
  logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, ext_wake = 1'h0, offchip_move = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0] level = 2'h0;
  logic pready, pslverr, core_reset, ring_active_status, addr_strobe;
  logic pfi_req, er, ps;
  logic [2:0] timer_tick;
  logic [15:0] pfi_vector;
  logic [7:0] rd;
  swpm_mon_s mon;
  swpm_pwr_s pwr;
  int n_fail = 0, check_count = 0, cyc = 0, k, nr;
  int nt [3];

  swpm_stop_wake #(.POR_CYCLES(16)) dut (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mon,
    .ext_wake, .offchip_move, .pwr, .core_reset, .ring_active_status,
    .addr_strobe, .timer_tick, .pfi_req, .pfi_vector);
  swpm_supply_model sup (.level, .mon);

  // clock and hang limit
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // one bus transfer, held until ready is seen
  task automatic apb(input logic w, input logic [9:0] i,
    input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  // count strobe rises and timer ticks over n clocks
  task automatic win(input int n);
    nr = 0;
    nt = '{0, 0, 0};
    ps = addr_strobe;
    repeat (n)
    begin
      @(posedge clk);
      if (addr_strobe && !ps) nr++;
      ps = addr_strobe;
      for (int j = 0; j < 3; j++) nt[j] += timer_tick[j];
    end
  endtask : win

  task automatic por_wait;
    wt(10);
    chk(core_reset, 1'h1);
    for (k = 0; k < 40 && core_reset !== 1'h0; k++) @(posedge clk);
    chk(core_reset, 1'h0);
  endtask : por_wait

  initial
  begin
    wt(16);
    nrst <= 1'h1;
    por_wait();
    $display("power-up done");
    foreach (ROWS[i])
    begin
      apb(1'h0, ROWS[i].idx, 8'h00);
      chk(rd, 8'h00);
      apb(1'h1, ROWS[i].idx, ROWS[i].wd);
      apb(1'h0, ROWS[i].idx, 8'h00);
      chk(rd, ROWS[i].rd);
    end
    apb(1'h0, 10'h100, 8'h00);
    chk(er, 1'h1);
    chk(rd, 8'h00);
    $display("register rows done");
    apb(1'h1, 10'h08E, 8'h10);
    wt(24);
    win(48);
    chk(nt[0], 4);
    chk(nt[1], 12);
    chk(nt[2], 4);
    apb(1'h1, 10'h0F0, 8'h00);
    wt(8);
    win(40);
    chk(nr, 10);
    apb(1'h1, 10'h0F0, 8'h04);
    wt(8);
    win(40);
    chk(nr, 0);
    offchip_move <= 1'h1;
    wt(8);
    win(40);
    chk(nr, 10);
    offchip_move <= 1'h0;
    $display("rate and strobe done");
    apb(1'h1, 10'h0C7, 8'hAA);
    apb(1'h1, 10'h0C7, 8'h55);
    apb(1'h1, 10'h091, 8'h03);
    apb(1'h0, 10'h091, 8'h00);
    chk(rd, 8'h03);
    apb(1'h1, 10'h087, 8'h02);
    wt(2);
    chk(pwr, 4'h9);
    ext_wake <= 1'h1;
    @(posedge clk);
    ext_wake <= 1'h0;
    wt(2);
    chk(ring_active_status, 1'h1);
    apb(1'h0, 10'h091, 8'h00);
    chk(rd, 8'h07);
    for (k = 0; k < 40 && pwr.ring_on !== 1'h0; k++) @(posedge clk);
    chk(pwr, 4'h5);
    $display("ring wake done");
    apb(1'h1, 10'h091, 8'h01);
    apb(1'h1, 10'h087, 8'h02);
    level <= 2'h1;
    wt(6);
    chk(pwr, 4'h5);
    chk(pfi_req, 1'h1);
    chk(pfi_vector, 16'h0033);
    level <= 2'h0;
    wt(4);
    apb(1'h0, 10'h0D8, 8'h00);
    chk(rd, 8'h30);
    apb(1'h1, 10'h0D8, 8'h20);
    apb(1'h0, 10'h0D8, 8'h00);
    chk(rd, 8'h20);
    apb(1'h1, 10'h0D8, 8'h00);
    apb(1'h1, 10'h087, 8'h02);
    level <= 2'h1;
    wt(8);
    chk(pwr.clocks_off, 1'h1);
    level <= 2'h0;
    ext_wake <= 1'h1;
    @(posedge clk);
    ext_wake <= 1'h0;
    wt(3);
    chk(pwr, 4'h5);
    $display("warning wake done");
    level <= 2'h2;
    wt(4);
    chk(core_reset, 1'h1);
    level <= 2'h0;
    por_wait();
    $display("brown-out done");
    apb(1'h1, 10'h0C7, 8'hAA);
    apb(1'h1, 10'h0C7, 8'h55);
    apb(1'h1, 10'h091, 8'h00);
    apb(1'h1, 10'h087, 8'h02);
    wt(2);
    chk(pwr, 4'h8);
    level <= 2'h2;
    wt(6);
    chk(pwr, 4'h8);
    chk(core_reset, 1'h0);
    level <= 2'h0;
    wt(3);
    ext_wake <= 1'h1;
    @(posedge clk);
    ext_wake <= 1'h0;
    wt(3);
    chk(pwr, 4'h5);
    $display("unmonitored stop done");
    nrst <= 1'h0;
    wt(2);
    chk(core_reset, 1'h1);
    nrst <= 1'h1;
    por_wait();
    apb(1'h0, 10'h091, 8'h00);
    chk(rd, 8'h00);
    apb(1'h0, 10'h0D8, 8'h00);
    chk(rd, 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule : swpm_stop_wake_test
